// *** rtl/urt_pkg.sv ***
// Constants, types and shared decode for the receive-timeout and flag block
package urt_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PERIOD_W = 22;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] TMO_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] FLAG_OFS = 8'h18;

  // Reset values
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 22'h1FF;
  localparam logic [DATA_W-1:0]   FLAG_RST   = 32'h0000_1E90;
  localparam logic [DATA_W-1:0]   READ_ZERO  = 32'h0000_0000;

  // Flag register field positions
  localparam int unsigned CTS_BIT      = 0;
  localparam int unsigned BUSY_BIT     = 3;
  localparam int unsigned RX_EMPTY_BIT = 4;
  localparam int unsigned TX_FULL_BIT  = 5;
  localparam int unsigned RX_FULL_BIT  = 6;
  localparam int unsigned TX_EMPTY_BIT = 7;
  localparam int unsigned CTS_CHG_BIT  = 9;
  localparam int unsigned RSV_HI_LSB   = 10;
  localparam int unsigned RSV_HI_MSB   = 12;
  localparam int unsigned HALT_BIT     = 13;
  localparam logic [2:0]  RSV_HI_VAL   = 3'h7;

  // Oversampling factors; the tick input runs at the 16x rate
  localparam int unsigned OVS_LO_SEL = 16;
  localparam int unsigned OVS_HI_SEL = 8;
  localparam int unsigned TICKS_PER_COUNT_HI = OVS_LO_SEL / OVS_HI_SEL;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } urt_bus_req_t;

  // Holding register and FIFO levels from the data path
  typedef struct packed {
    logic rx_fifo_empty;
    logic rx_fifo_full;
    logic rx_hold_full;
    logic tx_fifo_empty;
    logic tx_fifo_full;
    logic tx_hold_full;
  } urt_lvl_t;

  // Transmitter state from the shifter and flow control
  typedef struct packed {
    logic tx_enable;
    logic tx_shifting;
    logic xoff_sent;
    logic xon_sent;
  } urt_tx_t;

  // Pick the FIFO or holding-register view of a level
  function automatic logic sel_level(input logic fifo_mode, input logic fifo_lvl, input logic hold_lvl);
    return fifo_mode ? fifo_lvl : hold_lvl;
  endfunction

endpackage

// *** rtl/urt_sync.sv ***
// Two-stage synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module urt_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Level in and out
  input  wire logic d_i,
  output logic      q_o
);
  import urt_pkg::*;

  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  // Next values of both stages
  always_comb begin
    meta_next = d_i;
    q_next    = meta_reg;
  end

  // Register both stages
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= 1'b0;
      q_reg    <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q_o = q_reg;

  chk_sync_delay: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i, 2) |-> q_o == $past(d_i, 2))
    else $error("synchroniser output is not the input two cycles late");
endmodule
`default_nettype wire

// *** rtl/urt_timeout.sv ***
// Receive-timeout counter running on oversample ticks
`timescale 1ns/1ps
`default_nettype none
module urt_timeout (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  // Tick and control
  input  wire logic                        tick_i,
  input  wire logic                        half_rate_i,
  input  wire logic                        run_i,
  input  wire logic                        restart_i,
  input  wire logic [urt_pkg::PERIOD_W-1:0] period_i,
  // Timeout level
  output logic                             expired_o
);
  import urt_pkg::*;

  logic                ph_reg;
  logic                ph_next;
  logic [PERIOD_W-1:0] cnt_reg;
  logic [PERIOD_W-1:0] cnt_next;
  logic                exp_reg;
  logic                exp_next;
  logic                step;

  // factor 8 counts every second 16x tick
  always_comb begin
    ph_next = ph_reg;
    if (!run_i || restart_i) begin
      ph_next = 1'b0;
    end else if (tick_i && half_rate_i) begin
      ph_next = ~ph_reg;
    end
    step = tick_i && (!half_rate_i || ph_reg);
  end

  // count idle sample periods while data waits
  // restart on a new character, hold at zero when empty
  always_comb begin
    cnt_next = cnt_reg;
    exp_next = exp_reg;
    if (!run_i || restart_i) begin
      cnt_next = '0;
      exp_next = 1'b0;
    end else if (step && !exp_reg) begin
      cnt_next = cnt_reg + PERIOD_W'(1);
      exp_next = (cnt_next >= period_i);
    end
  end

  // Register counter state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_reg  <= 1'b0;
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end else begin
      ph_reg  <= ph_next;
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expired_o = exp_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_tmo_idle_clear: assert property ((!run_i || restart_i) |=> !expired_o && cnt_reg == '0)
    else $error("timeout not cleared while idle or restarted");
  chk_tmo_fire_exact: assert property (
    (run_i && !restart_i && step && !exp_reg && cnt_reg + PERIOD_W'(1) >= period_i) |=> expired_o)
    else $error("timeout did not fire at the programmed count");
  chk_tmo_half_rate: assert property ((tick_i && half_rate_i && !ph_reg) |-> !step)
    else $error("factor 8 counted on every tick");
endmodule
`default_nettype wire

// *** rtl/urt_flags_top.sv ***
// Receive timeout and flag register of the serial port
// Contract
// - Timeout period is 22 bits, low bits of its register, reset 0x1FF.
// - Timeout interrupt when receive data waits and nothing arrives for the period.
// - Period counts at 16x baud, or 8x baud when oversample select is one.
// - Bit 0 shows clear-to-send; bit 9 sets on its change, reset one.
// - Busy bit 3 stays set until the last stop bit has left.
// - Disabling mid-character clears busy; re-enabling sets it again.
// - Busy sets at once when transmit FIFO is non-empty, enabled or not.
// - Bit 4 shows receive holding register or FIFO empty, reset one.
// - Bit 5 shows transmit holding register or FIFO full.
// - Bit 6 shows receive holding register or FIFO full.
// - Bit 7 shows transmit holding register or FIFO empty, reset one.
// - Bit 13 sets when Xoff is sent, clears when Xon is sent.
// - Receive FIFO enable zero means single holding register, one means FIFO.
`timescale 1ns/1ps
`default_nettype none
module urt_flags_top (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         nrst_i,
  // Register port
  input  wire urt_pkg::urt_bus_req_t        bus_i,
  output logic [urt_pkg::DATA_W-1:0]        rdata_o,
  // Modem pin
  input  wire logic                         cts_i,
  // Data path status
  input  wire urt_pkg::urt_lvl_t            lvl_i,
  input  wire urt_pkg::urt_tx_t             tx_i,
  input  wire logic                         rx_fifo_enable_i,
  input  wire logic                         fifo_enable_i,
  input  wire logic                         oversample_select_i,
  input  wire logic                         baud16_tick_i,
  input  wire logic                         rx_char_written_i,
  // Status outputs
  output logic [urt_pkg::DATA_W-1:0]        flag_status_o,
  output logic [urt_pkg::PERIOD_W-1:0]      period_o,
  output logic                              rx_timeout_o
);
  import urt_pkg::*;

  typedef enum logic [1:0] {
    URT_TX_IDLE,
    URT_TX_SEND,
    URT_TX_PAUSE
  } urt_tx_state_t;

  logic [PERIOD_W-1:0] period_reg;
  logic [PERIOD_W-1:0] period_next;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;
  logic [DATA_W-1:0]   flag_reg;
  logic [DATA_W-1:0]   flag_next;
  logic                cts_prev_reg;
  logic                cts_prev_next;
  logic                cts_chg_reg;
  logic                cts_chg_next;
  logic                halt_reg;
  logic                halt_next;
  urt_tx_state_t       tx_state_reg;
  urt_tx_state_t       tx_state_next;
  logic                cts_sync;
  logic                wr_tmo;
  logic                rd_flag;
  logic                rd_tmo;
  logic                rx_empty;
  logic                rx_full;
  logic                tx_empty;
  logic                tx_full;

  // Clear-to-send pin enters through two flip-flops
  urt_sync u_cts_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (cts_i),
    .q_o    (cts_sync)
  );

  // Address decode
  always_comb begin
    wr_tmo  = bus_i.wr && (bus_i.addr == TMO_OFS);
    rd_flag = bus_i.rd && (bus_i.addr == FLAG_OFS);
    rd_tmo  = bus_i.rd && (bus_i.addr == TMO_OFS);
  end

  // mode picks holding register or FIFO level
  always_comb begin
    // receive side follows its own enable
    rx_empty = sel_level(rx_fifo_enable_i, lvl_i.rx_fifo_empty, !lvl_i.rx_hold_full);
    rx_full  = sel_level(rx_fifo_enable_i, lvl_i.rx_fifo_full, lvl_i.rx_hold_full);
    // transmit side follows the shared enable
    tx_empty = sel_level(fifo_enable_i, lvl_i.tx_fifo_empty, !lvl_i.tx_hold_full);
    tx_full  = sel_level(fifo_enable_i, lvl_i.tx_fifo_full, lvl_i.tx_hold_full);
  end

  // timeout period register, upper bits read as zero
  always_comb begin
    period_next = period_reg;
    if (wr_tmo) begin
      period_next = bus_i.wdata[PERIOD_W-1:0];
    end
  end

  // timeout counter, runs while receive data waits
  // each new character restarts the count
  urt_timeout u_timeout (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .tick_i      (baud16_tick_i),
    .half_rate_i (oversample_select_i),
    .run_i       (!rx_empty),
    .restart_i   (rx_char_written_i),
    .period_i    (period_reg),
    .expired_o   (rx_timeout_o)
  );

  // change detect on the synchronised level; a change beats the read clear
  // A read clears only a change its image already showed, so none is lost
  always_comb begin
    cts_prev_next = cts_sync;
    cts_chg_next  = cts_chg_reg;
    if (cts_sync != cts_prev_reg) begin
      cts_chg_next = 1'b1;
    end else if (rd_flag && flag_reg[CTS_CHG_BIT]) begin
      cts_chg_next = 1'b0;
    end
  end

  // halted on Xoff sent, released on Xon sent; set wins
  always_comb begin
    halt_next = halt_reg;
    if (tx_i.xoff_sent) begin
      halt_next = 1'b1;
    end else if (tx_i.xon_sent) begin
      halt_next = 1'b0;
    end
  end

  // Transmit activity tracking for the busy flag
  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      URT_TX_IDLE,
      URT_TX_SEND,
      URT_TX_PAUSE: begin
        // queued data sets busy even when disabled
        if (!tx_empty) begin
          tx_state_next = URT_TX_SEND;
        // held until the last stop bit has left
        end else if (tx_i.tx_shifting && tx_i.tx_enable) begin
          tx_state_next = URT_TX_SEND;
        end else if (tx_i.tx_shifting) begin
          tx_state_next = URT_TX_PAUSE;
        end else begin
          tx_state_next = URT_TX_IDLE;
        end
      end
      default: begin
        tx_state_next = URT_TX_IDLE;
      end
    endcase
  end

  // Flag register image
  always_comb begin
    flag_next                          = READ_ZERO;
    flag_next[CTS_BIT]                 = cts_sync;
    flag_next[BUSY_BIT]                = (tx_state_reg == URT_TX_SEND);
    flag_next[RX_EMPTY_BIT]            = rx_empty;
    flag_next[TX_FULL_BIT]             = tx_full;
    flag_next[RX_FULL_BIT]             = rx_full;
    flag_next[TX_EMPTY_BIT]            = tx_empty;
    // change since the last shown read
    flag_next[CTS_CHG_BIT]             = cts_chg_reg;
    flag_next[RSV_HI_MSB:RSV_HI_LSB]   = RSV_HI_VAL;
    flag_next[HALT_BIT]                = halt_reg;
  end

  // Read data for the cycle after the strobe; zero otherwise
  always_comb begin
    rdata_next = READ_ZERO;
    if (rd_flag) begin
      rdata_next = flag_reg;
    end else if (rd_tmo) begin
      rdata_next[PERIOD_W-1:0] = period_reg;
    end
  end

  // Register all state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      period_reg   <= PERIOD_RST;
      rdata_reg    <= READ_ZERO;
      flag_reg     <= FLAG_RST;
      cts_prev_reg <= 1'b0;
      cts_chg_reg  <= 1'b1;
      halt_reg     <= 1'b0;
      tx_state_reg <= URT_TX_IDLE;
    end else begin
      period_reg   <= period_next;
      rdata_reg    <= rdata_next;
      flag_reg     <= flag_next;
      cts_prev_reg <= cts_prev_next;
      cts_chg_reg  <= cts_chg_next;
      halt_reg     <= halt_next;
      tx_state_reg <= tx_state_next;
    end
  end

  // Outputs straight from registers
  assign rdata_o       = rdata_reg;
  assign flag_status_o = flag_reg;
  assign period_o      = period_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_tmo_write;
    wr_tmo ##1 1'b1;
  endsequence

  sequence s_cts_edge;
    (cts_sync != cts_prev_reg);
  endsequence

  sequence s_pause_resume;
    (tx_state_reg == URT_TX_PAUSE) ##1 (tx_empty && tx_i.tx_shifting && tx_i.tx_enable);
  endsequence

  chk_period_write: assert property (wr_tmo |=> period_reg == $past(bus_i.wdata[PERIOD_W-1:0]))
    else $error("timeout period not stored");
  chk_period_readback: assert property (s_tmo_write ##0 rd_tmo |=>
    rdata_o == {{(DATA_W-PERIOD_W){1'b0}}, $past(period_reg)})
    else $error("timeout period read back wrong");
  chk_cts_delta_set: assert property (s_cts_edge |=> cts_chg_reg ##1 flag_status_o[CTS_CHG_BIT])
    else $error("clear-to-send change not flagged");
  chk_cts_delta_clear: assert property (
    (rd_flag && flag_status_o[CTS_CHG_BIT] && !(cts_sync != cts_prev_reg)) |=> !cts_chg_reg)
    else $error("delta flag not cleared by read");
  chk_cts_level: assert property (1'b1 |=> flag_status_o[CTS_BIT] == $past(cts_sync))
    else $error("clear-to-send level wrong");
  chk_busy_queued: assert property (!tx_empty |=> ##1 flag_status_o[BUSY_BIT])
    else $error("busy not set with queued transmit data");
  chk_busy_paused: assert property ((tx_empty && tx_i.tx_shifting && !tx_i.tx_enable) |=> ##1
    !flag_status_o[BUSY_BIT])
    else $error("busy not cleared while disabled mid-character");
  chk_busy_idle: assert property ((tx_empty && !tx_i.tx_shifting) |=> ##1 !flag_status_o[BUSY_BIT])
    else $error("busy held after the character left");
  chk_rx_empty_mode: assert property (1'b1 |=> flag_status_o[RX_EMPTY_BIT] ==
    $past(rx_fifo_enable_i ? lvl_i.rx_fifo_empty : !lvl_i.rx_hold_full))
    else $error("receive empty flag wrong for the mode");
  chk_tx_full_mode: assert property (1'b1 |=> flag_status_o[TX_FULL_BIT] ==
    $past(fifo_enable_i ? lvl_i.tx_fifo_full : lvl_i.tx_hold_full))
    else $error("transmit full flag wrong for the mode");
  chk_rx_full_mode: assert property (1'b1 |=> flag_status_o[RX_FULL_BIT] ==
    $past(rx_fifo_enable_i ? lvl_i.rx_fifo_full : lvl_i.rx_hold_full))
    else $error("receive full flag wrong for the mode");
  chk_tx_empty_mode: assert property (1'b1 |=> flag_status_o[TX_EMPTY_BIT] ==
    $past(fifo_enable_i ? lvl_i.tx_fifo_empty : !lvl_i.tx_hold_full))
    else $error("transmit empty flag wrong for the mode");
  chk_halt_flow: assert property (tx_i.xoff_sent |=> halt_reg ##1 flag_status_o[HALT_BIT])
    else $error("halt flag not set after Xoff");
  chk_halt_release: assert property ((tx_i.xon_sent && !tx_i.xoff_sent) |=> !halt_reg)
    else $error("halt flag not cleared after Xon");
  chk_tmo_empty: assert property (rx_empty |=> !rx_timeout_o)
    else $error("timeout raised with nothing received");

  // Register port: reads answer once, reserved timeout bits read zero
  chk_period_reserved: assert property (rd_tmo |=> rdata_o[DATA_W-1:PERIOD_W] == '0)
    else $error("reserved timeout bits not zero");
  chk_rdata_idle: assert property (!bus_i.rd |=> rdata_o == READ_ZERO)
    else $error("read data stood longer than one cycle");
  chk_rdata_flags: assert property (rd_flag |=> rdata_o == $past(flag_reg))
    else $error("flag read returned a stale image");

  // Clear-to-send delta: held until a read has shown it
  chk_cts_delta_hold: assert property ((cts_chg_reg && !rd_flag) |=> cts_chg_reg)
    else $error("delta flag dropped without a read");
  chk_cts_unseen_keep: assert property (
    (rd_flag && cts_chg_reg && !flag_status_o[CTS_CHG_BIT]) |=> cts_chg_reg)
    else $error("delta flag cleared before it was shown");

  // Busy: shifting with the transmitter on, and resume after a pause
  chk_busy_shifting: assert property ((tx_empty && tx_i.tx_shifting && tx_i.tx_enable) |=> ##1
    flag_status_o[BUSY_BIT])
    else $error("busy dropped while the character is shifting");
  chk_busy_resume: assert property (s_pause_resume |=> ##1 flag_status_o[BUSY_BIT])
    else $error("busy not set again on re-enable");

  // Flow control and timeout restart
  chk_halt_hold: assert property ((!tx_i.xoff_sent && !tx_i.xon_sent) |=> halt_reg == $past(halt_reg))
    else $error("halt flag moved without Xoff or Xon");
  chk_tmo_restart: assert property (rx_char_written_i |=> !rx_timeout_o)
    else $error("timeout not cleared by a new character");
endmodule
`default_nettype wire

// *** testbench/urt_remote.sv ***
// Remote serial device: clear-to-send pin and received characters
`timescale 1ns/1ps
`default_nettype none
module urt_remote (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Commands from the bench
  input  wire logic send_i,
  input  wire logic cts_req_i,
  // Pins toward the block
  output logic      cts_o,
  output logic      char_o
);
  logic cts_q = 1'b0;

  // Pin moves off the clock grid, like a real far end
  always @(cts_req_i) begin
    cts_q <= #7 cts_req_i;
  end
  assign cts_o = cts_q;

  // One pulse per character landing in the receive side
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      char_o <= 1'b0;
    end else begin
      char_o <= send_i;
    end
  end
endmodule
`default_nettype wire

// *** testbench/test_uart_rx_timeout_and_flags.sv ***
// Self-checking bench for the receive timeout and flag block
`timescale 1ns/1ps
`default_nettype none
module test_uart_rx_timeout_and_flags;
  import urt_pkg::*;
  logic                clk_i = 1'b0;
  logic                nrst_i = 1'b0;
  urt_bus_req_t        bus = '0;
  logic [DATA_W-1:0]   rdata, flags, d, w;
  urt_lvl_t            lvl = 6'h24;
  urt_lvl_t            l;
  urt_tx_t             tx = '0;
  logic                rx_fen = 1'b1;
  logic                fifo_enable = 1'b1;
  logic                ovs = 1'b0;
  logic                tick = 1'b0;
  logic                send = 1'b0;
  logic                cts_req = 1'b0;
  logic                cts, chr, tmo, rf, tf;
  logic [PERIOD_W-1:0] period;
  logic [3:0]          busy_tab [5] = '{4'h1, 4'hF, 4'hA, 4'hF, 4'hC};
  logic [2:0]          halt_tab [4] = '{3'h5, 3'h2, 3'h7, 3'h2};
  int                  num_errors = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;

  urt_flags_top i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata), .cts_i(cts), .lvl_i(lvl), .tx_i(tx),
    .rx_fifo_enable_i(rx_fen), .fifo_enable_i(fifo_enable), .oversample_select_i(ovs), .baud16_tick_i(tick),
    .rx_char_written_i(chr), .flag_status_o(flags), .period_o(period), .rx_timeout_o(tmo)
  );

  urt_remote i_remote (
    .clk_i(clk_i), .nrst_i(nrst_i), .send_i(send), .cts_req_i(cts_req), .cts_o(cts), .char_o(chr)
  );

  // Clock and hang guard
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      complete_run();
    end
  end

  // Expected receive and transmit level bits 7:4
  function automatic logic [3:0] exp_lvl(input urt_lvl_t v, input logic r, input logic t);
    return {t ? v.tx_fifo_empty : !v.tx_hold_full, r ? v.rx_fifo_full : v.rx_hold_full,
            t ? v.tx_fifo_full : v.tx_hold_full, r ? v.rx_fifo_empty : !v.rx_hold_full};
  endfunction

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_i);
    bus.addr  <= a;
    bus.wdata <= v;
    bus.wr    <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Write then read with no gap between the strobes
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v, output logic [DATA_W-1:0] q);
    @(posedge clk_i);
    bus.addr  <= a;
    bus.wdata <= v;
    bus.wr    <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
    end
    settle(1);
  endtask

  task automatic new_char();
    @(posedge clk_i);
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    settle(2);
  endtask

  // One timeout run: o selects factor, fm selects FIFO or holding register
  task automatic tmo_case(input logic o, input logic fm, input int nlo, input int nhi);
    @(posedge clk_i);
    ovs    <= o;
    rx_fen <= fm;
    lvl    <= '{rx_fifo_empty: !fm, rx_hold_full: 1'b1, default: 1'b0};
    new_char();
    ticks(nlo);
    chk({31'h0, tmo}, 32'h0);
    ticks(nhi - nlo);
    chk({31'h0, tmo}, 32'h1);
    new_char();
    chk({31'h0, tmo}, 32'h0);
    ticks(nhi);
    chk({31'h0, tmo}, 32'h1);
    @(posedge clk_i);
    lvl.rx_fifo_empty <= 1'b1;
    lvl.rx_hold_full  <= 1'b0;
    settle(3);
    chk({31'h0, tmo}, 32'h0);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    w = $urandom(60);
    settle(1);
    chk(flags, FLAG_RST);
    chk({10'h0, period}, {10'h0, PERIOD_RST});
    @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(TMO_OFS, d);
    chk(d, {10'h0, PERIOD_RST});
    // Period field width, read-only and unmapped places
    repeat (4) begin
      w = $urandom;
      wr_rd(TMO_OFS, w, d);
      chk(d, {10'h0, w[21:0]});
      chk({10'h0, period}, {10'h0, w[21:0]});
    end
    wr(FLAG_OFS, 32'hFFFF_FFFF);
    wr(8'h10, 32'h0000_0005);
    rd(8'h10, d);
    chk(d, READ_ZERO);
    rd(TMO_OFS, d);
    chk(d, {10'h0, w[21:0]});
    // Level flags in both modes
    repeat (16) begin
      l  = 6'($urandom);
      rf = 1'($urandom);
      tf = 1'($urandom);
      @(posedge clk_i);
      lvl    <= l;
      rx_fen <= rf;
      fifo_enable    <= tf;
      settle(2);
      chk({28'h0, flags[7:4]}, {28'h0, exp_lvl(l, rf, tf)});
    end
    // Busy through queue, shifting, pause and resume
    @(posedge clk_i);
    fifo_enable <= 1'b1;
    lvl <= 6'h24;
    foreach (busy_tab[i]) begin
      @(posedge clk_i);
      lvl.tx_fifo_empty <= busy_tab[i][3];
      tx.tx_enable      <= busy_tab[i][2];
      tx.tx_shifting    <= busy_tab[i][1];
      settle(3);
      chk({31'h0, flags[BUSY_BIT]}, {31'h0, busy_tab[i][0]});
    end
    // Clear-to-send level and its change flag
    rd(FLAG_OFS, d);
    chk({31'h0, d[CTS_CHG_BIT]}, 32'h1);
    settle(2);
    rd(FLAG_OFS, d);
    chk({31'h0, d[CTS_CHG_BIT]}, 32'h0);
    for (int k = 1; k >= 0; k--) begin
      cts_req <= 1'(k);
      settle(6);
      chk({30'h0, flags[CTS_CHG_BIT], flags[CTS_BIT]}, {30'h0, 1'b1, 1'(k)});
      rd(FLAG_OFS, d);
      settle(2);
      chk({31'h0, flags[CTS_CHG_BIT]}, 32'h0);
    end
    // Xoff and Xon pulses, set winning on a tie
    foreach (halt_tab[i]) begin
      @(posedge clk_i);
      tx.xoff_sent <= halt_tab[i][2];
      tx.xon_sent  <= halt_tab[i][1];
      @(posedge clk_i);
      tx.xoff_sent <= 1'b0;
      tx.xon_sent  <= 1'b0;
      settle(2);
      chk({31'h0, flags[HALT_BIT]}, {31'h0, halt_tab[i][0]});
    end
    // Receive timeout with both factors and both receive modes
    wr(TMO_OFS, 32'h0000_0003);
    tmo_case(1'b0, 1'b1, 2, 3);
    tmo_case(1'b1, 1'b1, 4, 6);
    tmo_case(1'b0, 1'b0, 2, 3);
    complete_run();
  end
endmodule
`default_nettype wire
